// >>> aace_pkg.sv
// Shared constants, register map and carrier types of the add/AND/call execution unit
package aace_pkg;
    // Bus geometry
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    // Register byte offsets
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_WORK = 8'h04;
    localparam logic [7:0] OFF_FLAGS = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0c;
    localparam logic [7:0] OFF_MADDR = 8'h10;
    localparam logic [7:0] OFF_MDATA = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    // Storage sizes
    localparam int MEM_DEPTH = 16;
    localparam int MEM_AW = 4;
    localparam int PC_W = 12;
    localparam int STK_DEPTH = 8;
    localparam int STK_AW = 3;
    localparam int DEPTH_W = 4;
    localparam logic [DEPTH_W-1:0] DEPTH_FULL = 4'h8;
    // Instruction word fields
    localparam int OP_LSB = 0;
    localparam int OPND_LSB = 8;
    localparam int TGT_LSB = 16;
    // Status word fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DEPTH_LSB = 4;
    localparam int STAT_TOP_LSB = 16;
    // Opcodes
    localparam logic [2:0] OP_NOP = 3'h0;
    localparam logic [2:0] OP_ADD_TO_MEMORY = 3'h1;
    localparam logic [2:0] OP_AND_MEM_TO_WR = 3'h2;
    localparam logic [2:0] OP_AND_IMM = 3'h3;
    localparam logic [2:0] OP_AND_INTO_MEMORY = 3'h4;
    localparam logic [2:0] OP_CALL = 3'h5;
    // Reset values and steps
    localparam logic [7:0] WR_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 12'h000;
    localparam logic [PC_W-1:0] PC_STEP = 12'h001;
    localparam logic [STK_AW-1:0] SP_STEP = 3'h1;
    localparam logic [DEPTH_W-1:0] DEPTH_STEP = 4'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Latched instruction
    typedef struct packed {
        logic [PC_W-1:0] target;
        logic [7:0] operand;
        logic [2:0] op;
    } aace_instr_type;

    // Status flags, low bit last
    typedef struct packed {
        logic sign_result;
        logic carry;
        logic nibble_carry;
        logic zero;
        logic signed_wrap;
    } aace_flags_type;

    // Sequencer, Gray from idle through push to jump
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_PUSH = 2'h1,
        ST_JUMP = 2'h3,
        ST_ONE = 2'h2
    } aace_state_type;
endpackage

// >>> aace_core.sv
// Execution unit for add-to-memory, the AND forms and subroutine call, AXI4-Lite controlled
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// What this block does
// - Add working register into memory, five flags
// - AND memory into working register, zero only
// - AND immediate into working register, zero only
// - AND working register into memory byte
// - Call pushes program counter plus one
// - Call then loads target into program counter
// - Call takes two instruction cycles
module aace_core (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic BUSY
);
    ////////////////////////////////////////////////////////////////////////////
    // Architectural state
    aace_pkg::aace_state_type state_q, state_d; // Sequencer
    aace_pkg::aace_instr_type instr_q, instr_d; // Instruction under way
    aace_pkg::aace_flags_type flags_q, flags_d; // Status flags
    logic [7:0] wr_q, wr_d; // working_register
    logic [aace_pkg::PC_W-1:0] pc_q, pc_d; // Program counter
    logic [aace_pkg::MEM_AW-1:0] maddr_q, maddr_d; // Software memory pointer
    logic [7:0] mem_q [aace_pkg::MEM_DEPTH]; // Data memory
    logic [aace_pkg::PC_W-1:0] stk_q [aace_pkg::STK_DEPTH]; // Return stack
    logic [aace_pkg::STK_AW-1:0] sp_q, sp_d; // Next free slot, wraps
    logic [aace_pkg::DEPTH_W-1:0] depth_q, depth_d; // Saturating fill count
    logic mem_we; // One write port, execution wins
    logic [aace_pkg::MEM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic stk_we;
    logic busy_q, busy_d;
    // Bus side state
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    // Datapath helpers
    logic [aace_pkg::MEM_AW-1:0] ea; // Operand address
    logic [7:0] mop; // Operand byte
    logic [8:0] sum; // Sum with carry out
    logic [4:0] nib; // Low nibble sum
    logic [7:0] andv; // AND result
    logic wr_fire, start;

    // Byte-lane merge of a bus write into a register image
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Operand datapath
    assign ea = instr_q.operand[aace_pkg::MEM_AW-1:0];
    assign mop = mem_q[ea];
    assign sum = {1'b0, wr_q} + {1'b0, mop};
    assign nib = {1'b0, wr_q[3:0]} + {1'b0, mop[3:0]};
    // AND against immediate or memory operand
    assign andv = wr_q & ((instr_q.op == aace_pkg::OP_AND_IMM) ? instr_q.operand : mop);
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
    // Instruction writes while busy are dropped, not queued
    assign start = wr_fire && awaddr_q == aace_pkg::OFF_INSTR && state_q == aace_pkg::ST_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes; one write and one read outstanding at most
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        // Address and data accepted in either order
        if (S_AXI_AWVALID && awready_q) begin
            aw_full_d = 1'b1;
            awaddr_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wready_q) begin
            w_full_d = 1'b1;
            wdata_d = S_AXI_WDATA;
            wstrb_d = S_AXI_WSTRB;
        end
        if (bvalid_q && S_AXI_BREADY) begin
            bvalid_d = 1'b0;
        end
        // Both halves present: commit and answer
        if (wr_fire) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (awaddr_q > aace_pkg::OFF_STAT || awaddr_q[1:0] != 2'h0) ?
                      aace_pkg::RESP_SLVERR : aace_pkg::RESP_OKAY;
        end
        if (rvalid_q && S_AXI_RREADY) begin
            rvalid_d = 1'b0;
        end
        // Read data captured at address handshake
        if (S_AXI_ARVALID && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = aace_pkg::RESP_OKAY;
            rdata_d = '0;
            unique case (S_AXI_ARADDR)
                aace_pkg::OFF_INSTR: rdata_d = 32'(instr_q);
                aace_pkg::OFF_WORK: rdata_d = 32'(wr_q);
                aace_pkg::OFF_FLAGS: rdata_d = 32'(flags_q);
                aace_pkg::OFF_PC: rdata_d = 32'(pc_q);
                aace_pkg::OFF_MADDR: rdata_d = 32'(maddr_q);
                aace_pkg::OFF_MDATA: rdata_d = 32'(mem_q[maddr_q]);
                aace_pkg::OFF_STAT: begin
                    rdata_d[aace_pkg::STAT_BUSY_BIT] = busy_q;
                    rdata_d[aace_pkg::STAT_DEPTH_LSB +: aace_pkg::DEPTH_W] = depth_q;
                    rdata_d[aace_pkg::STAT_TOP_LSB +: aace_pkg::PC_W] =
                        stk_q[sp_q - aace_pkg::SP_STEP];
                end
                default: rresp_d = aace_pkg::RESP_SLVERR; // Unmapped reads as zero
            endcase
        end
        // Ready only while the matching slot is free
        awready_d = !aw_full_d && !bvalid_d;
        wready_d = !w_full_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes, then execution; execution overrides a clashing bus write
    always_comb begin
        logic [31:0] img;
        img = '0;
        state_d = state_q;
        instr_d = instr_q;
        flags_d = flags_q;
        wr_d = wr_q;
        pc_d = pc_q;
        maddr_d = maddr_q;
        sp_d = sp_q;
        depth_d = depth_q;
        mem_we = 1'b0;
        mem_wa = maddr_q;
        mem_wd = mem_q[maddr_q];
        stk_we = 1'b0;
        if (wr_fire) begin
            unique case (awaddr_q)
                aace_pkg::OFF_WORK: begin
                    img = merge(32'(wr_q), wdata_q, wstrb_q);
                    wr_d = img[7:0];
                end
                aace_pkg::OFF_FLAGS: begin
                    img = merge(32'(flags_q), wdata_q, wstrb_q);
                    flags_d = img[$bits(aace_pkg::aace_flags_type)-1:0];
                end
                aace_pkg::OFF_PC: begin
                    img = merge(32'(pc_q), wdata_q, wstrb_q);
                    pc_d = img[aace_pkg::PC_W-1:0];
                end
                aace_pkg::OFF_MADDR: begin
                    img = merge(32'(maddr_q), wdata_q, wstrb_q);
                    maddr_d = img[aace_pkg::MEM_AW-1:0];
                end
                aace_pkg::OFF_MDATA: begin
                    img = merge(32'(mem_q[maddr_q]), wdata_q, wstrb_q);
                    mem_we = 1'b1;
                    mem_wd = img[7:0];
                end
                default: ; // Instruction, status and holes store nothing here
            endcase
        end
        unique case (state_q)
            aace_pkg::ST_IDLE: begin
                if (start) begin
                    // Fields unpacked at their bus positions, not as one packed slice
                    instr_d.op = wdata_q[aace_pkg::OP_LSB +: 3];
                    instr_d.operand = wdata_q[aace_pkg::OPND_LSB +: 8];
                    instr_d.target = wdata_q[aace_pkg::TGT_LSB +: aace_pkg::PC_W];
                    state_d = (instr_d.op == aace_pkg::OP_CALL) ? aace_pkg::ST_PUSH
                                                                : aace_pkg::ST_ONE;
                end
            end
            aace_pkg::ST_ONE: begin
                pc_d = pc_q + aace_pkg::PC_STEP;
                state_d = aace_pkg::ST_IDLE;
                unique case (instr_q.op)
                    aace_pkg::OP_ADD_TO_MEMORY: begin
                        mem_we = 1'b1;
                        mem_wa = ea;
                        mem_wd = sum[7:0];
                        flags_d.carry = sum[8];
                        flags_d.nibble_carry = nib[4];
                        flags_d.zero = (sum[7:0] == aace_pkg::BYTE_ZERO);
                        // Overflow when like-signed operands give an unlike sign
                        flags_d.signed_wrap = (wr_q[7] == mop[7]) && (sum[7] != wr_q[7]);
                        flags_d.sign_result = flags_d.signed_wrap ^ sum[7];
                    end
                    aace_pkg::OP_AND_MEM_TO_WR, aace_pkg::OP_AND_IMM: begin
                        wr_d = andv;
                        flags_d.zero = (andv == aace_pkg::BYTE_ZERO);
                    end
                    aace_pkg::OP_AND_INTO_MEMORY: begin
                        mem_we = 1'b1;
                        mem_wa = ea;
                        mem_wd = andv;
                        flags_d.zero = (andv == aace_pkg::BYTE_ZERO);
                    end
                    default: ; // Unknown opcodes only advance the counter
                endcase
            end
            aace_pkg::ST_PUSH: begin
                stk_we = 1'b1;
                sp_d = sp_q + aace_pkg::SP_STEP;
                // Deeper nesting overwrites the oldest entry
                if (depth_q != aace_pkg::DEPTH_FULL) begin
                    depth_d = depth_q + aace_pkg::DEPTH_STEP;
                end
                state_d = aace_pkg::ST_JUMP;
            end
            aace_pkg::ST_JUMP: begin
                pc_d = instr_q.target;
                state_d = aace_pkg::ST_IDLE;
            end
        endcase
        busy_d = (state_d != aace_pkg::ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; CE low freezes everything
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q <= aace_pkg::ST_IDLE;
            instr_q <= '0;
            flags_q <= '0;
            wr_q <= aace_pkg::WR_RST;
            pc_q <= aace_pkg::PC_RST;
            maddr_q <= '0;
            sp_q <= '0;
            depth_q <= '0;
            busy_q <= 1'b0;
            for (int i = 0; i < aace_pkg::MEM_DEPTH; i++) begin
                mem_q[i] <= aace_pkg::BYTE_ZERO;
            end
            for (int i = 0; i < aace_pkg::STK_DEPTH; i++) begin
                stk_q[i] <= aace_pkg::PC_RST;
            end
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= aace_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= aace_pkg::RESP_OKAY;
            rdata_q <= '0;
        end else if (CE) begin
            state_q <= state_d;
            instr_q <= instr_d;
            flags_q <= flags_d;
            wr_q <= wr_d;
            pc_q <= pc_d;
            maddr_q <= maddr_d;
            sp_q <= sp_d;
            depth_q <= depth_d;
            busy_q <= busy_d;
            if (mem_we) begin
                mem_q[mem_wa] <= mem_wd;
            end
            if (stk_we) begin
                stk_q[sp_q] <= pc_q + aace_pkg::PC_STEP;
            end
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RRESP = rresp_q;
    assign S_AXI_RDATA = rdata_q;
    assign BUSY = busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_one(logic [2:0] o);
        CE && state_q == aace_pkg::ST_ONE && instr_q.op == o;
    endsequence
    sequence s_call;
        CE && state_q == aace_pkg::ST_PUSH ##1 CE && state_q == aace_pkg::ST_JUMP;
    endsequence

    a_add_mem_sum: assert property (s_one(aace_pkg::OP_ADD_TO_MEMORY) |=>
        mem_q[$past(ea)] == 8'($past(wr_q) + $past(mop)) && flags_q.carry == $past(sum[8]))
        else $error("add-to-memory result or carry wrong");
    a_and_mem_wr: assert property (s_one(aace_pkg::OP_AND_MEM_TO_WR) |=>
        wr_q == ($past(wr_q) & $past(mop)) && flags_q.carry == $past(flags_q.carry))
        else $error("AND memory into working register wrong");
    a_and_imm_wr: assert property (s_one(aace_pkg::OP_AND_IMM) |=>
        wr_q == ($past(wr_q) & $past(instr_q.operand)) && flags_q.zero == (wr_q == 8'h00))
        else $error("AND immediate wrong");
    a_and_into_mem: assert property (s_one(aace_pkg::OP_AND_INTO_MEMORY) |=>
        mem_q[$past(ea)] == ($past(wr_q) & $past(mop)))
        else $error("AND into memory wrong");
    a_and_keeps_wr: assert property (s_one(aace_pkg::OP_AND_INTO_MEMORY) |=>
        $stable(wr_q) && flags_q.signed_wrap == $past(flags_q.signed_wrap))
        else $error("AND into memory disturbed register or flags");
    a_call_push_ret: assert property (CE && state_q == aace_pkg::ST_PUSH |=>
        stk_q[$past(sp_q)] == $past(pc_q) + 12'h001 && $stable(flags_q))
        else $error("call pushed wrong return address");
    a_call_jump_pc: assert property (s_call |=> pc_q == $past(instr_q.target))
        else $error("call did not load target");
    a_call_two_cyc: assert property (s_call |=>
        state_q == aace_pkg::ST_IDLE && !BUSY)
        else $error("call did not finish in two cycles");
endmodule

// >>> test_add_and_call_instruction_exec.sv
// Self-checking testbench of the add/AND/call execution unit
`timescale 1ns/1ps
module test_add_and_call_instruction_exec;
    logic sys_clk = 1'b0; // 50 MHz system clock
    logic rst = 1'b1; // Held for eight cycles at start
    logic ce = 1'b1; // Tied: freezing is not exercised here
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf; // Tied: every write is a whole word
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic busy;
    int err_count = 0;
    int n_checks = 0;
    int busy_cnt = 0; // Edges at which the unit reported busy

    aace_core dut (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .BUSY(busy));

    // Clock source
    always #10 sys_clk = ~sys_clk;

    // Busy edge counter, read as a difference so no reset race
    always @(posedge sys_clk) begin
        if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A stuck handshake ends the run at once
    task automatic timed_out();
        err_count++;
        $display("[FAIL] %0t wait bound used up", $time);
        complete_run();
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: response %h expected %h", $time, what, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bus master: each valid held until its own ready is sampled high
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
                             output logic [1:0] resp);
        int i;
        @(posedge sys_clk);
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        timed_out();
    endtask

    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
                            output logic [1:0] resp);
        int i;
        @(posedge sys_clk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                data = rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        timed_out();
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [1:0] r;
        axi_write(addr, data, r);
        check_resp(r, aace_pkg::RESP_OKAY, "write response");
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(addr, d, r);
        check_word(d, exp, what);
    endtask

    task automatic set_mem(input logic [3:0] ptr, input logic [7:0] val);
        wr(aace_pkg::OFF_MADDR, {28'h0, ptr});
        wr(aace_pkg::OFF_MDATA, {24'h0, val});
    endtask

    // Issue one instruction, then wait for the unit to go idle
    task automatic run_instr(input logic [2:0] op, input logic [7:0] opnd, input logic [11:0] tgt);
        int i;
        wr(aace_pkg::OFF_INSTR, {4'h0, tgt, opnd, 5'h00, op});
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (busy === 1'b0) return;
        end
        timed_out();
    endtask

    // Expected flag word: [4] sign, [3] carry, [2] nibble carry, [1] zero, [0] wrap
    function automatic logic [31:0] add_flags(input logic [7:0] a, input logic [7:0] m);
        logic [8:0] s;
        logic wrap;
        s = {1'b0, a} + {1'b0, m};
        wrap = (a[7] == m[7]) && (s[7] != a[7]);
        return {27'h0, wrap ^ s[7], s[8], ({1'b0, a[3:0]} + {1'b0, m[3:0]}) > 5'h0f,
                s[7:0] == 8'h00, wrap};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset_map();
        logic [31:0] d;
        logic [1:0] r;
        rd_chk(aace_pkg::OFF_WORK, 32'h0, "register after reset");
        rd_chk(aace_pkg::OFF_FLAGS, 32'h0, "flags after reset");
        rd_chk(aace_pkg::OFF_STAT, 32'h0, "status after reset");
        axi_read(8'h1c, d, r);
        check_resp(r, aace_pkg::RESP_SLVERR, "unmapped read");
        check_word(d, 32'h0, "unmapped read data");
        axi_write(8'h06, 32'h0000_00ff, r);
        check_resp(r, aace_pkg::RESP_SLVERR, "unaligned write");
        $display("Test reset and map done");
    endtask

    // Flag corners: plain wrap, carry to zero, negative plus negative
    task automatic test_add();
        logic [7:0] a_tab [3] = '{8'h01, 8'hff, 8'h80};
        logic [7:0] m_tab [3] = '{8'h7f, 8'h01, 8'h80};
        logic [7:0] s;
        int b0;
        int k;
        for (k = 0; k < 3; k++) begin
            wr(aace_pkg::OFF_WORK, {24'h0, a_tab[k]});
            set_mem(4'(k + 2), m_tab[k]);
            b0 = busy_cnt;
            run_instr(aace_pkg::OP_ADD_TO_MEMORY, 8'(k + 2), 12'h000);
            check_word(32'(busy_cnt - b0), 32'h1, "single cycle");
            s = a_tab[k] + m_tab[k];
            rd_chk(aace_pkg::OFF_MDATA, {24'h0, s}, "sum in memory");
            rd_chk(aace_pkg::OFF_FLAGS, add_flags(a_tab[k], m_tab[k]), "add flags");
            rd_chk(aace_pkg::OFF_WORK, {24'h0, a_tab[k]}, "register kept");
        end
        $display("Test add done");
    endtask

    // Each AND form, once with zero and once with nonzero result
    task automatic test_and();
        logic [2:0] ops [3] = '{aace_pkg::OP_AND_MEM_TO_WR, aace_pkg::OP_AND_IMM,
                                aace_pkg::OP_AND_INTO_MEMORY};
        logic [7:0] v;
        logic [7:0] res;
        logic [31:0] fexp;
        int k;
        for (k = 0; k < 6; k++) begin
            v = (k < 3) ? 8'h3c : 8'h5a;
            res = 8'hc3 & v;
            wr(aace_pkg::OFF_WORK, 32'h0000_00c3);
            wr(aace_pkg::OFF_FLAGS, 32'h0000_001d);
            // Memory differs from the immediate so a wrong source shows
            set_mem(4'h5, (k % 3 == 1) ? 8'hff : v);
            run_instr(ops[k % 3], (k % 3 == 1) ? v : 8'h05, 12'h000);
            // Only the zero bit may move from the preset pattern
            fexp = {27'h0, 5'h1d | {3'h0, res == 8'h00, 1'b0}};
            rd_chk(aace_pkg::OFF_FLAGS, fexp, "zero flag only");
            case (k % 3)
                0: rd_chk(aace_pkg::OFF_WORK, {24'h0, res}, "and memory");
                1: rd_chk(aace_pkg::OFF_WORK, {24'h0, res}, "and immediate");
                default: begin
                    rd_chk(aace_pkg::OFF_MDATA, {24'h0, res}, "and into memory");
                    rd_chk(aace_pkg::OFF_WORK, 32'h0000_00c3, "register kept");
                end
            endcase
        end
        $display("Test and done");
    endtask

    // Calls, one from the top of program space so the return wraps
    task automatic test_call();
        logic [11:0] pc_tab [2] = '{12'h123, 12'hfff};
        logic [11:0] tg_tab [2] = '{12'habc, 12'h040};
        logic [31:0] sexp;
        int b0;
        int k;
        for (k = 0; k < 2; k++) begin
            wr(aace_pkg::OFF_FLAGS, 32'h0000_0015);
            wr(aace_pkg::OFF_PC, {20'h0, pc_tab[k]});
            b0 = busy_cnt;
            run_instr(aace_pkg::OP_CALL, 8'h00, tg_tab[k]);
            check_word(32'(busy_cnt - b0), 32'h2, "call cycles");
            // Top of stack in [27:16], depth in [7:4], idle
            sexp = {4'h0, 12'(pc_tab[k] + 12'h001), 8'h00, 4'(k + 1), 4'h0};
            rd_chk(aace_pkg::OFF_STAT, sexp, "return address");
            rd_chk(aace_pkg::OFF_FLAGS, 32'h0000_0015, "flags kept");
            rd_chk(aace_pkg::OFF_PC, {20'h0, tg_tab[k]}, "jump target");
            run_instr(aace_pkg::OP_NOP, 8'h00, 12'h000);
            rd_chk(aace_pkg::OFF_PC, {20'h0, tg_tab[k] + 12'h001}, "run on");
        end
        $display("Test call done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset_map();
        test_add();
        test_and();
        test_call();
        complete_run();
    end
endmodule
